// ### hdl/mss_seq_map.vh
// Purpose: constants of the multislope adc sequencer
// Assumes: 11-bit conversion counter, 250 MHz oscillator clock
// Notes: counts are conversion counter values
`ifndef MSS_SEQ_MAP_VH
`define MSS_SEQ_MAP_VH

// ===================================================================
// command register fields
`define MSS_CMD_START_BIT 7
`define MSS_CMD_50HZ_BIT 6
`define MSS_CMD_SLEEP_BIT 5
`define MSS_CMD_RDZERO_BIT 4
`define MSS_CMD_RS0_BIT 2
`define MSS_CMD_RS1_BIT 1
`define MSS_CMD_RESET 8'h00
`define MSS_START_HOLD 3'h5

// ===================================================================
// register select codes {reg_select_high, reg_select_low}
`define MSS_SEL_LOW 2'h0
`define MSS_SEL_HIGH 2'h1
`define MSS_SEL_STATUS 2'h2
`define MSS_SEL_INVALID 2'h3
`define MSS_INVALID_DATA 8'h00

// ===================================================================
// status register fields
`define MSS_ST_COLL_BIT 7
`define MSS_ST_EOC_BIT 6
`define MSS_ST_INT_BIT 5
`define MSS_ST_SLEEP_BIT 4

// ===================================================================
// conversion counter landmarks
`define MSS_CNT_IDLE 11'h000
`define MSS_CNT_FIRST 11'h001
`define MSS_CNT_LAST 11'd1819
`define MSS_CYCLE_LEN 11'd1820
`define MSS_ZI_EXTRA_60 11'd111
`define MSS_ZI_EXTRA_50 11'd1
`define MSS_INT_LEN_60 11'd545
`define MSS_INT_LEN_50 11'd655
`define MSS_INT_END 11'd656
`define MSS_D1_START 11'd657
`define MSS_D1_END 11'd1256
`define MSS_X8A_END 11'd1320
`define MSS_D2_END 11'd1440
`define MSS_X8B_END 11'd1504
`define MSS_D3_END 11'd1624
`define MSS_X8C_END 11'd1688
`define MSS_D4_END 11'd1799
`define MSS_ZI_TAIL 11'd20

// ===================================================================
// results counter in eighths of a count
`define MSS_ACC_W 19
`define MSS_STEP_D1 19'd512
`define MSS_STEP_D2 19'd64
`define MSS_STEP_D3 19'd8
`define MSS_STEP_D4 19'd1

`endif

// ### hdl/mss_cmd_reg.v
// Purpose: command input register with self-clearing start bit
// Assumes: host strobes synchronous to the clock
// Notes: start clears a fixed number of clocks after acceptance
`timescale 1ns/100ps
`include "mss_seq_map.vh"

module mss_cmd_reg (
    input wire clk_i,            // oscillator clock
    input wire rst_n_i,          // sync reset, active low
    input wire wr_stb_i,         // one-cycle write pulse
    input wire [7:0] wdata_i,    // host write data
    input wire accept_i,         // sequencer took the start
    output reg [7:0] cmd_o       // command register contents
);

    reg [2:0] hold_r;
    reg [2:0] hold_nxt;
    reg [7:0] cmd_nxt;

    // ===============================================================
    // next state of command and start hold counter
    always @* begin
        cmd_nxt = cmd_o;
        hold_nxt = hold_r;
        if (accept_i) begin
            hold_nxt = `MSS_START_HOLD;
        end else if (hold_r != 3'h0) begin
            hold_nxt = hold_r - 3'h1;
        end
        // start drops after the hold expires
        if (hold_r == 3'h1) begin
            cmd_nxt[`MSS_CMD_START_BIT] = 1'b0;
        end
        // a host write wins over the self clear
        if (wr_stb_i) begin
            cmd_nxt = wdata_i;
        end
    end

    // ===============================================================
    // state registers
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_o <= `MSS_CMD_RESET;
            hold_r <= 3'h0;
        end else begin
            cmd_o <= cmd_nxt;
            hold_r <= hold_nxt;
        end
    end

endmodule

// ### hdl/mss_result_acc.v
// Purpose: up/down results counter and results register
// Assumes: step already weighted by deintegrate phase
// Notes: value held in eighths of a count, twos complement
`timescale 1ns/100ps
`include "mss_seq_map.vh"

module mss_result_acc (
    input wire clk_i,                      // oscillator clock
    input wire rst_n_i,                    // sync reset, active low
    input wire clear_i,                    // zero counter at conversion start
    input wire count_i,                    // deintegrating this clock
    input wire up_i,                       // count direction
    input wire [`MSS_ACC_W-1:0] step_i,    // phase weight
    input wire latch_i,                    // conversion end
    output reg [`MSS_ACC_W-1:0] result_o   // results register
);

    reg [`MSS_ACC_W-1:0] acc_r;

    // ===============================================================
    // accumulate during deintegration, copy at conversion end
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_r <= {`MSS_ACC_W{1'b0}};
            result_o <= {`MSS_ACC_W{1'b0}};
        end else begin
            if (clear_i) begin
                acc_r <= {`MSS_ACC_W{1'b0}};
            end else if (count_i && up_i) begin
                acc_r <= acc_r + step_i;
            end else if (count_i) begin
                acc_r <= acc_r - step_i;
            end
            if (latch_i) begin
                result_o <= acc_r;
            end
        end
    end

endmodule

// ### hdl/mss_sequencer.v
// Purpose: conversion sequencer, results and host readout of a
//          multislope integrating adc
// Assumes: host strobes and comparator synchronous to CLK_I
// Notes: data bus split into input, output and output enable
`timescale 1ns/100ps
`include "mss_seq_map.vh"

module mss_sequencer (
    input wire CLK_I,            // oscillator clock, 250 MHz
    input wire RST_N_I,          // sync reset, active low
    input wire CS_N_I,           // chip select, active low
    input wire RD_N_I,           // read strobe, active low
    input wire WR_N_I,           // write strobe, active low
    input wire [7:0] DATA_I,     // data bus input side
    input wire COMP_I,           // comparator, high for positive integrator
    output reg [7:0] DATA_O,     // data bus output side
    output wire DATA_OE_O,       // data bus drive enable
    output reg EOC_O,            // conversion done
    output reg ZERO_INT_O,       // zero integrate phase
    output reg INTEGRATE_O,      // integrate phase
    output reg DEINT_O,          // deintegrate switch closed
    output reg DEINT_UP_O,       // deintegrate polarity, high counts up
    output reg REST_O,           // rest phase
    output reg TIMES_EIGHT_O,    // residual_times_eight_phase
    output reg READ_ZERO_O       // inputs shorted for this conversion
);

    // ===============================================================
    // local state
    reg [10:0] cnt_r;
    reg [10:0] cnt_nxt;
    reg run_r;
    reg over_r;
    reg pol_r;
    reg rd_act_r;
    reg stat_rd_r;
    reg coll_r;
    reg [1:0] sel;
    reg [7:0] rd_byte;
    reg [10:0] int_start;
    reg [10:0] win_end;
    reg [1:0] win_idx;
    reg in_win;
    reg win_first;
    reg in_x8;
    reg [`MSS_ACC_W-1:0] step;

    wire [7:0] cmd;
    wire [`MSS_ACC_W-1:0] result;
    wire wr_stb;
    wire rd_act;
    wire accept;
    wire crossing;
    wire latch_end;
    wire mode_50;

    // ===============================================================
    // host strobes
    assign wr_stb = !CS_N_I && !WR_N_I;
    assign rd_act = !CS_N_I && !RD_N_I;
    assign DATA_OE_O = rd_act;

    // ===============================================================
    // start accepted only with counter at 0000
    assign accept = cmd[`MSS_CMD_START_BIT] && (cnt_r == `MSS_CNT_IDLE);
    assign mode_50 = cmd[`MSS_CMD_50HZ_BIT];
    assign latch_end = (cnt_r == `MSS_CNT_LAST);

    mss_cmd_reg u_cmd (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .wr_stb_i(wr_stb),
        .wdata_i(DATA_I),
        .accept_i(accept),
        .cmd_o(cmd)
    );

    // ===============================================================
    // conversion counter: hold at 0000, launch to 0001, wrap at end
    always @* begin
        if (cnt_r == `MSS_CNT_IDLE) begin
            if (accept) begin
                cnt_nxt = `MSS_CNT_FIRST;
            end else begin
                cnt_nxt = `MSS_CNT_IDLE;
            end
        end else if (cnt_r == `MSS_CYCLE_LEN - 11'h001) begin
            cnt_nxt = `MSS_CNT_IDLE;
        end else begin
            cnt_nxt = cnt_r + 11'h001;
        end
    end

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnt_r <= `MSS_CNT_IDLE;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ===============================================================
    // integrate start depends on line mode; end is common
    always @* begin
        if (mode_50) begin
            int_start = `MSS_INT_END - `MSS_INT_LEN_50 + 11'h001;
        end else begin
            int_start = `MSS_INT_END - `MSS_INT_LEN_60 + 11'h001;
        end
    end

    // ===============================================================
    // deintegrate window decode, index and weight
    always @* begin
        in_win = 1'b0;
        in_x8 = 1'b0;
        win_idx = 2'h0;
        win_end = `MSS_D1_END;
        win_first = 1'b0;
        if (cnt_r >= `MSS_D1_START && cnt_r <= `MSS_D1_END) begin
            in_win = 1'b1;
            win_idx = 2'h0;
            win_end = `MSS_D1_END;
            win_first = (cnt_r == `MSS_D1_START);
        end else if (cnt_r > `MSS_D1_END && cnt_r <= `MSS_X8A_END) begin
            in_x8 = 1'b1;
        end else if (cnt_r > `MSS_X8A_END && cnt_r <= `MSS_D2_END) begin
            in_win = 1'b1;
            win_idx = 2'h1;
            win_end = `MSS_D2_END;
            win_first = (cnt_r == `MSS_X8A_END + 11'h001);
        end else if (cnt_r > `MSS_D2_END && cnt_r <= `MSS_X8B_END) begin
            in_x8 = 1'b1;
        end else if (cnt_r > `MSS_X8B_END && cnt_r <= `MSS_D3_END) begin
            in_win = 1'b1;
            win_idx = 2'h2;
            win_end = `MSS_D3_END;
            win_first = (cnt_r == `MSS_X8B_END + 11'h001);
        end else if (cnt_r > `MSS_D3_END && cnt_r <= `MSS_X8C_END) begin
            in_x8 = 1'b1;
        end else if (cnt_r > `MSS_X8C_END && cnt_r <= `MSS_D4_END) begin
            in_win = 1'b1;
            win_idx = 2'h3;
            win_end = `MSS_D4_END;
            win_first = (cnt_r == `MSS_X8C_END + 11'h001);
        end
    end

    // weight of one clock per deintegrate phase
    always @* begin
        case (win_idx)
            2'h0: step = `MSS_STEP_D1;
            2'h1: step = `MSS_STEP_D2;
            2'h2: step = `MSS_STEP_D3;
            default: step = `MSS_STEP_D4;
        endcase
    end

    // ===============================================================
    // deintegrate run control: start at window, stop at crossing
    assign crossing = run_r && !over_r && (COMP_I != pol_r);

    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            run_r <= 1'b0;
            over_r <= 1'b0;
            pol_r <= 1'b0;
        end else if (win_first) begin
            // integrator polarity picks direction
            run_r <= 1'b1;
            over_r <= 1'b0;
            pol_r <= COMP_I;
        end else if (!in_win || cnt_r == win_end) begin
            // window maximum reached, rest is over
            run_r <= 1'b0;
            over_r <= 1'b0;
        end else if (over_r) begin
            // one clock past the crossing done
            run_r <= 1'b0;
            over_r <= 1'b0;
        end else if (crossing && win_idx != 2'h3) begin
            over_r <= 1'b1;
        end else if (crossing) begin
            run_r <= 1'b0;
        end
    end

    // ===============================================================
    // results counter, cleared at launch and copied at the end
    mss_result_acc u_acc (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .clear_i(cnt_r == `MSS_CNT_FIRST),
        .count_i(run_r),
        .up_i(pol_r),
        .step_i(step),
        .latch_i(latch_end),
        .result_o(result)
    );

    // ===============================================================
    // phase outputs, registered; EOC, zero integrate and integrate from the next count
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            EOC_O <= 1'b1;
            ZERO_INT_O <= 1'b1;
            INTEGRATE_O <= 1'b0;
            DEINT_O <= 1'b0;
            DEINT_UP_O <= 1'b0;
            REST_O <= 1'b0;
            TIMES_EIGHT_O <= 1'b0;
            READ_ZERO_O <= 1'b0;
        end else begin
            EOC_O <= (cnt_nxt == `MSS_CNT_IDLE);
            // idle, lead-in and 20-clock tail zero integrate
            ZERO_INT_O <= (cnt_nxt < int_start) ||
                          (cnt_nxt > `MSS_CYCLE_LEN - `MSS_ZI_TAIL - 11'h001);
            INTEGRATE_O <= (cnt_nxt >= int_start) && (cnt_nxt <= `MSS_INT_END);
            DEINT_O <= run_r;
            DEINT_UP_O <= pol_r;
            REST_O <= in_win && !run_r && !win_first;
            TIMES_EIGHT_O <= in_x8;
            if (accept) begin
                READ_ZERO_O <= cmd[`MSS_CMD_RDZERO_BIT];
            end
        end
    end

    // ===============================================================
    // register select and readout byte
    always @* begin
        sel = {cmd[`MSS_CMD_RS1_BIT], cmd[`MSS_CMD_RS0_BIT]};
        rd_byte = `MSS_INVALID_DATA;
        if (sel == `MSS_SEL_LOW) begin
            rd_byte = result[10:3];
        end else if (sel == `MSS_SEL_HIGH) begin
            rd_byte = result[18:11];
        end else if (sel == `MSS_SEL_STATUS) begin
            rd_byte = 8'h00;
            rd_byte[`MSS_ST_COLL_BIT] = coll_r;
            rd_byte[`MSS_ST_EOC_BIT] = EOC_O;
            rd_byte[`MSS_ST_INT_BIT] = INTEGRATE_O;
            rd_byte[`MSS_ST_SLEEP_BIT] = cmd[`MSS_CMD_SLEEP_BIT];
            rd_byte[2:0] = result[2:0];
        end
    end

    // ===============================================================
    // data out register, collision flag; set wins over read clear
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            DATA_O <= 8'h00;
            rd_act_r <= 1'b0;
            stat_rd_r <= 1'b0;
            coll_r <= 1'b0;
        end else begin
            DATA_O <= rd_byte;
            rd_act_r <= rd_act;
            stat_rd_r <= rd_act && (sel == `MSS_SEL_STATUS);
            if (latch_end && (rd_act || rd_act_r)) begin
                coll_r <= 1'b1;
            end else if (stat_rd_r && !rd_act) begin
                coll_r <= 1'b0;
            end
        end
    end

endmodule

// ### verif/mss_seq_properties.sv
// Purpose: concurrent checks on the sequencer top ports
// Assumes: one clock, sync active-low reset
// Notes: run lengths held in small helper counters
`timescale 1ns/100ps

module mss_seq_properties (
    input wire CLK_I,          // oscillator clock
    input wire RST_N_I,        // sync reset, active low
    input wire CS_N_I,         // chip select
    input wire RD_N_I,         // read strobe
    input wire WR_N_I,         // write strobe
    input wire [7:0] DATA_I,   // bus input
    input wire COMP_I,         // comparator
    input wire [7:0] DATA_O,   // bus output
    input wire DATA_OE_O,      // bus enable
    input wire EOC_O,          // conversion done
    input wire ZERO_INT_O,     // zero integrate
    input wire INTEGRATE_O,    // integrate
    input wire DEINT_O,        // deintegrate
    input wire DEINT_UP_O,     // deintegrate polarity
    input wire REST_O,         // rest
    input wire TIMES_EIGHT_O,  // times eight
    input wire READ_ZERO_O     // read zero
);
    int eoc_low_r;
    int int_len_r;
    int x8_len_r;
    int zi_run_r;

    // ===================================================================
    // phase run lengths
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            eoc_low_r <= 0;
            int_len_r <= 0;
            x8_len_r <= 0;
            zi_run_r <= 0;
        end else begin
            eoc_low_r <= EOC_O ? 0 : eoc_low_r + 1;
            int_len_r <= INTEGRATE_O ? int_len_r + 1 : 0;
            x8_len_r <= TIMES_EIGHT_O ? x8_len_r + 1 : 0;
            zi_run_r <= (ZERO_INT_O && !EOC_O) ? zi_run_r + 1 : 0;
        end
    end

    // ===================================================================
    // properties
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_start_wr;
        !CS_N_I && !WR_N_I && DATA_I[7] && EOC_O;
    endsequence
    sequence s_launched;
        ##[1:2] !EOC_O;
    endsequence

    a_bus_enable: assert property (DATA_OE_O == (!CS_N_I && !RD_N_I))
        else $error("bus enable differs from strobes");
    a_start_launch: assert property (s_start_wr |-> s_launched)
        else $error("start in idle did not launch");
    a_cycle_span: assert property ($rose(EOC_O) |-> eoc_low_r == 1819)
        else $error("conversion span wrong");
    a_int_length: assert property ($fell(INTEGRATE_O) |-> (int_len_r == 545 || int_len_r == 655))
        else $error("integrate length wrong");
    a_int_alone: assert property (INTEGRATE_O |-> !ZERO_INT_O && !EOC_O && !DEINT_O)
        else $error("integrate overlaps other phase");
    a_idle_zero: assert property (EOC_O |-> ZERO_INT_O && !INTEGRATE_O && !REST_O)
        else $error("idle not in zero integrate");
    a_rest_follows: assert property ($fell(DEINT_O) |-> REST_O || TIMES_EIGHT_O || ZERO_INT_O)
        else $error("no rest after deintegrate");
    a_x8_length: assert property ($fell(TIMES_EIGHT_O) |-> x8_len_r == 64)
        else $error("times eight length wrong");
    a_zi_tail: assert property ($rose(EOC_O) |-> zi_run_r == 20)
        else $error("tail zero integrate wrong");
    a_zi_front: assert property ($rose(INTEGRATE_O) |-> (zi_run_r == 111 || zi_run_r == 1))
        else $error("front zero integrate wrong");
endmodule

bind mss_sequencer mss_seq_properties i_props (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CS_N_I(CS_N_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I),
    .DATA_I(DATA_I), .COMP_I(COMP_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .EOC_O(EOC_O),
    .ZERO_INT_O(ZERO_INT_O), .INTEGRATE_O(INTEGRATE_O), .DEINT_O(DEINT_O),
    .DEINT_UP_O(DEINT_UP_O), .REST_O(REST_O), .TIMES_EIGHT_O(TIMES_EIGHT_O),
    .READ_ZERO_O(READ_ZERO_O)
);

// ### verif/mss_afe_model.sv
// Purpose: behavioural integrator and comparator
// Assumes: charge in integer units per clock
// Notes: read zero shorts the input to nothing
`timescale 1ns/100ps

module mss_afe_model #(
    parameter int OFS = 0   // system offset charge per integrate clock
) (
    input wire clk_i,     // oscillator clock
    input int vin_i,      // input charge per clock
    input int ref_i,      // reference charge per clock
    input wire zi_i,      // zero integrate
    input wire integ_i,   // integrate
    input wire deint_i,   // deintegrate
    input wire up_i,      // deintegrate polarity
    input wire x8_i,      // times eight
    input wire rz_i,      // inputs shorted
    output wire comp_o    // integrator positive
);
    int acc = 0;
    logic x8_d = 1'b0;

    // comparator sees integrator sign
    assign comp_o = (acc > 0);

    // ===================================================================
    // integrator
    always @(posedge clk_i) begin
        x8_d <= x8_i;
        if (zi_i) begin
            acc <= 0;
        end else if (integ_i) begin
            // offset stays in even with the inputs shorted
            acc <= acc + (rz_i ? 0 : vin_i) + OFS;
        end else if (deint_i) begin
            acc <= up_i ? acc - ref_i : acc + ref_i;
        end else if (x8_i && !x8_d) begin
            acc <= acc * 8;
        end
    end
endmodule

// ### verif/multislope_adc_sequencer_tb_top.sv
// Purpose: self-checking bench of the sequencer
// Assumes: inputs driven at the falling edge
// Notes: result checked within a band of counts
`timescale 1ns/100ps

module multislope_adc_sequencer_tb_top;
    localparam int REF = 4096;
    localparam int OFS = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic [7:0] din = 8'h00;
    wire comp, oe, eoc, zi, integ, deint, up, rest, x8, rz;
    wire [7:0] dout;
    logic [7:0] st;
    int vin = 0;
    int fail_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    mss_sequencer i_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
        .DATA_I(din), .COMP_I(comp), .DATA_O(dout), .DATA_OE_O(oe), .EOC_O(eoc),
        .ZERO_INT_O(zi), .INTEGRATE_O(integ), .DEINT_O(deint), .DEINT_UP_O(up),
        .REST_O(rest), .TIMES_EIGHT_O(x8), .READ_ZERO_O(rz)
    );
    mss_afe_model #(.OFS(OFS)) i_afe (
        .clk_i(clk), .vin_i(vin), .ref_i(REF), .zi_i(zi), .integ_i(integ), .deint_i(deint),
        .up_i(up), .x8_i(x8), .rz_i(rz), .comp_o(comp)
    );

    // ===================================================================
    // access tasks
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        wr_n = 1'b0;
        din = d;
        @(negedge clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
    endtask
    task rd(input logic [7:0] cmd, output logic [7:0] v);
        wr(cmd);
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        @(negedge clk);
        v = dout;
        cs_n = 1'b1;
        rd_n = 1'b1;
    endtask
    task wait_eoc;
        int n;
        n = 0;
        while (eoc !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
        end
    endtask

    // one conversion, phase lengths and result
    task run_conv(input logic [7:0] mode, input int v, input int zi_exp, input int int_exp);
        int n, lo_cnt, zi_cnt, in_cnt, res, expv;
        logic rz_seen;
        logic [7:0] lo, hi;
        n = 0;
        lo_cnt = 0;
        zi_cnt = 0;
        in_cnt = 0;
        vin = v;
        wr(mode | 8'h80);
        while (eoc !== 1'b0 && n < 4) begin
            @(negedge clk);
            n++;
        end
        rz_seen = rz;
        check("launch", n < 4, 1);
        while (eoc === 1'b0 && lo_cnt < 2000) begin
            lo_cnt++;
            zi_cnt += (zi === 1'b1);
            in_cnt += (integ === 1'b1);
            @(negedge clk);
        end
        check("cycle counts", lo_cnt, 1819);
        check("zero integrate", zi_cnt, zi_exp + 20);
        check("integrate", in_cnt, int_exp);
        check("read zero", rz_seen, mode[4]);
        rd(mode, lo);
        rd(mode | 8'h04, hi);
        rd(mode | 8'h02, st);
        res = $signed({hi, lo});
        expv = ((mode[4] ? 0 : v) + OFS) * int_exp * 64 / REF;
        check("result band", (res - expv <= 136) && (expv - res <= 136), 1);
        check("polarity", hi[7], ((mode[4] ? 0 : v) + OFS) < 0);
        check("status", st[7:3], 5'h08);
    endtask

    // ===================================================================
    // main sequence
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        check("reset phases", {eoc, zi, integ, oe}, 4'hc);
        run_conv(8'h00, 300, 111, 545);
        run_conv(8'h40, 300, 1, 655);
        run_conv(8'h00, -300, 111, 545);
        run_conv(8'h10, 300, 111, 545);
        repeat (50) @(negedge clk);
        check("idle hold", {eoc, zi, integ}, 3'h6);
        // start written mid conversion waits for count 0000
        wr(8'h80);
        repeat (200) @(negedge clk);
        wr(8'h80);
        wait_eoc();
        @(negedge clk);
        check("held start", eoc, 1'b0);
        // read left active across the result update
        repeat (1700) @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        wait_eoc();
        @(negedge clk);
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (3) @(negedge clk);
        check("start cleared", eoc, 1'b1);
        rd(8'h02, st);
        check("collision set", st[7], 1'b1);
        rd(8'h02, st);
        check("collision clear", st[7], 1'b0);
        rd(8'h06, st);
        check("invalid select", st, 8'h00);
        test_done();
    end

    // watchdog, over three times the planned run
    initial begin
        #(40000 * 4);
        fail_count++;
        test_done();
    end
endmodule
